// >>> logic/lbic_pkg.sv
// constants for the led blink and intrusion configuration block
package lbic_pkg;
   // register byte addresses (offsets are register indices: address = index * 4)
   localparam logic [7:0]  IDX_PIN_INTRUSION_LED_MODE_CFG = 8'h2B;
   localparam logic [7:0]  IDX_LED_BLINK_CFG              = 8'h2C;
   localparam logic [11:0] ADDR_PIN_INTRUSION_LED_MODE_CFG = {2'h0, IDX_PIN_INTRUSION_LED_MODE_CFG, 2'h0};
   localparam logic [11:0] ADDR_LED_BLINK_CFG              = {2'h0, IDX_LED_BLINK_CFG, 2'h0};
   localparam logic [11:0] ADDR_CTRL      = 12'h100;
   localparam logic [11:0] ADDR_IRQ_STAT  = 12'h104;
   localparam logic [11:0] ADDR_IRQ_MASK  = 12'h108;
   // pin/intrusion/led mode fields
   localparam int POS_PIN58_SEL   = 0;
   localparam int POS_PIN59_SEL   = 1;
   localparam int POS_LED_MODE    = 2;
   localparam int POS_INTR_STATUS = 4;
   localparam int POS_INTR_LEVEL  = 5;
   localparam int POS_PIN47_SEL   = 6;
   // blink cfg fields
   localparam int POS_LED1_RATE   = 0;
   localparam int POS_LED2_RATE   = 3;
   localparam int POS_PWR_LED_S45 = 6;
   localparam int POS_LED_TWO     = 7;
   // control register fields (own)
   localparam int POS_LED_POL     = 0;
   // interrupt status bits
   localparam int POS_IRQ_INTRUSION = 0;
   localparam int POS_IRQ_HWM1_LOAD = 1;
   // mode and rate codes, reset values
   localparam logic [1:0] LED_MODE_SW   = 2'h0;
   localparam logic [1:0] LED_MODE_HW1  = 2'h1;
   localparam logic [1:0] LED_MODE_HW2  = 2'h2;
   localparam logic [2:0] RATE_LOW      = 3'h0;
   localparam logic [2:0] RATE_0P25     = 3'h1;
   localparam logic [2:0] RATE_0P5      = 3'h2;
   localparam logic [2:0] RATE_1HZ      = 3'h3;
   localparam logic [2:0] RATE_2HZ      = 3'h4;
   localparam logic [2:0] RATE_3HZ      = 3'h5;
   localparam logic [2:0] RATE_4HZ      = 3'h6;
   localparam logic [2:0] RATE_HIGH     = 3'h7;
   localparam logic [2:0] LED1_RATE_RST = RATE_LOW;
   localparam logic [2:0] LED2_RATE_RST = RATE_HIGH;
   // timebase: one tick every 1/24 s gives 3 Hz and 4 Hz exactly
   localparam int  CLK_HZ         = 250_000_000;
   localparam int  TICK_HZ        = 24;
   localparam int  TICK_CYCLES    = CLK_HZ / TICK_HZ;
   localparam int  PHASE_STEPS    = 96;
   typedef enum logic [2:0]
   {
      LBIC_PWR_OFF  = 3'b001,
      LBIC_PWR_SB   = 3'b010,
      LBIC_PWR_MAIN = 3'b100
   } lbic_pwr_t;
endpackage

// >>> logic/lbic_blink_if.sv
// timebase phase shared between the top and the blink generator
`timescale 1ns/100ps
interface lbic_blink_if;
   logic [6:0] phase;
   logic [2:0] led1_rate;
   logic [2:0] led2_rate;
   logic       led1_wave;
   logic       led2_wave;
   modport ctrl (output led1_rate, output led2_rate, input led1_wave, input led2_wave,
                 input phase);
   modport gen  (input led1_rate, input led2_rate, output led1_wave, output led2_wave,
                 output phase);
endinterface

// >>> logic/lbic_blink_gen.sv
// slow timebase and blink waveform generator for two leds
`timescale 1ns/100ps
module lbic_blink_gen
#(
   parameter int TICK_CYCLES = lbic_pkg::TICK_CYCLES
)
(
   // clock and reset
   input  wire logic  pclk,
   input  wire logic  presetn,
   // blink channel
   lbic_blink_if.gen  bl
);
   logic [31:0] div_cnt;
   logic [6:0]  phase;
   wire         tick = (div_cnt == 32'(TICK_CYCLES - 1));

   // phase counts 96 ticks of 1/24 s: a 4 s period
   function automatic logic wave(input logic [2:0] rate, input logic [6:0] ph);
      case (rate)
         lbic_pkg::RATE_LOW:  wave = 1'b0;
         lbic_pkg::RATE_0P25: wave = (ph < 7'd12);
         lbic_pkg::RATE_0P5:  wave = ((ph % 7'd48) < 7'd12);
         lbic_pkg::RATE_1HZ:  wave = ((ph % 7'd24) < 7'd12);
         lbic_pkg::RATE_2HZ:  wave = ((ph % 7'd12) < 7'd6);
         lbic_pkg::RATE_3HZ:  wave = ((ph % 7'd8) < 7'd4);
         lbic_pkg::RATE_4HZ:  wave = ((ph % 7'd6) < 7'd3);
         default:             wave = 1'b1;
      endcase
   endfunction

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_cnt <= 32'h0;
         phase   <= 7'h0;
      end
      else
      begin
         div_cnt <= tick ? 32'h0 : div_cnt + 32'h1;
         if (tick)
            phase <= (phase == 7'(lbic_pkg::PHASE_STEPS - 1)) ? 7'h0 : phase + 7'h1;
      end
   end

   assign bl.phase     = phase;
   assign bl.led1_wave = wave(bl.led1_rate, phase);
   assign bl.led2_wave = wave(bl.led2_rate, phase);
endmodule // lbic_blink_gen

// >>> logic/lbic_top.sv
// led blink, pin select and intrusion configuration registers with apb slave
`timescale 1ns/100ps
module lbic_top
#(
   parameter int TICK_CYCLES = lbic_pkg::TICK_CYCLES
)
(
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // power and straps
   input  wire logic        main_pwr_ok,
   input  wire logic        standby_pwr_ok,
   input  wire logic        supply_control_straps_off,
   // chassis intrusion (active high)
   input  wire logic        chassis_switch_in,
   // pin routing selects
   output logic             pins_as_thermistors,
   output logic             pin59_infrared_rx_one,
   output logic             pin58_infrared_rx_two_sel_zero,
   // leds
   output logic             led1_out,
   output logic             led2_out,
   output logic             led_two_separate,
   output logic             power_led_force_off,
   output logic [1:0]       led_mode,
   // interrupt
   output logic             irq
);
   lbic_blink_if bl ();

   // register state (battery domain: presetn models the battery power-up)
   logic       pin47_sel;
   logic       intr_status;
   logic [1:0] mode;
   logic       pin59_sel;
   logic       pin58_sel;
   logic       led_two;
   logic       pwr_led_s45;
   logic [2:0] led2_rate;
   logic [2:0] led1_rate;
   logic       led_pol;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic       strap_taken;
   logic       main_d;
   logic       sb_d;
   lbic_pkg::lbic_pwr_t pwr_state;
   lbic_pkg::lbic_pwr_t next_pwr_state;

   // apb decode
   wire        acc        = psel & penable;
   wire        wr         = acc & pwrite;
   wire        hit_b      = (paddr == lbic_pkg::ADDR_PIN_INTRUSION_LED_MODE_CFG);
   wire        hit_c      = (paddr == lbic_pkg::ADDR_LED_BLINK_CFG);
   wire        hit_ctrl   = (paddr == lbic_pkg::ADDR_CTRL);
   wire        hit_stat   = (paddr == lbic_pkg::ADDR_IRQ_STAT);
   wire        hit_mask   = (paddr == lbic_pkg::ADDR_IRQ_MASK);
   wire        hit_any    = hit_b | hit_c | hit_ctrl | hit_stat | hit_mask;
   wire        wr_b       = wr & hit_b;
   wire        wr_c       = wr & hit_c;

   // power events
   wire        sb_rise    = standby_pwr_ok & ~sb_d;
   wire        main_fall  = ~main_pwr_ok & main_d & standby_pwr_ok;
   wire        main_up_ev = main_pwr_ok & ~main_d;
   wire        hw1_load   = (mode == lbic_pkg::LED_MODE_HW1) & (sb_rise | main_fall);
   wire        intr_set   = chassis_switch_in;
   wire        intr_new   = intr_set & ~intr_status;

   // read mux
   wire [7:0]  rd_b = {1'b0,
                       pin47_sel,
                       chassis_switch_in,
                       intr_status,
                       mode,
                       pin59_sel,
                       pin58_sel};
   wire [7:0]  rd_c = {led_two, pwr_led_s45, led2_rate, led1_rate};
   wire [31:0] rd_data = hit_b    ? {24'h0, rd_b} :
                         hit_c    ? {24'h0, rd_c} :
                         hit_ctrl ? {31'h0, led_pol} :
                         hit_stat ? {30'h0, irq_stat} :
                         hit_mask ? {30'h0, irq_mask} : 32'h0;

   // effective mode: reserved behaves as software
   wire [1:0]  eff_mode = (mode == 2'h3) ? lbic_pkg::LED_MODE_SW : mode;
   wire        pwr_off_hw2 = (eff_mode == lbic_pkg::LED_MODE_HW2) & ~pwr_led_s45 &
                             (pwr_state != lbic_pkg::LBIC_PWR_MAIN);

   // power state tracker
   always_comb
   begin
      next_pwr_state = pwr_state;
      case (pwr_state)
         lbic_pkg::LBIC_PWR_OFF:  if (main_pwr_ok) next_pwr_state = lbic_pkg::LBIC_PWR_MAIN;
                                  else if (standby_pwr_ok) next_pwr_state = lbic_pkg::LBIC_PWR_SB;
         lbic_pkg::LBIC_PWR_SB:   if (main_pwr_ok) next_pwr_state = lbic_pkg::LBIC_PWR_MAIN;
                                  else if (!standby_pwr_ok) next_pwr_state = lbic_pkg::LBIC_PWR_OFF;
         lbic_pkg::LBIC_PWR_MAIN: if (!main_pwr_ok)
                                     next_pwr_state = standby_pwr_ok ? lbic_pkg::LBIC_PWR_SB
                                                                     : lbic_pkg::LBIC_PWR_OFF;
         default:                 next_pwr_state = lbic_pkg::LBIC_PWR_OFF;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwr_state <= lbic_pkg::LBIC_PWR_OFF;
         main_d    <= 1'b0;
         sb_d      <= 1'b0;
      end
      else
      begin
         pwr_state <= next_pwr_state;
         main_d    <= main_pwr_ok;
         sb_d      <= standby_pwr_ok;
      end
   end

   // pin/intrusion/led mode register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin47_sel   <= 1'b0;
         intr_status <= 1'b1;
         mode        <= lbic_pkg::LED_MODE_SW;
         pin59_sel   <= 1'b0;
         pin58_sel   <= 1'b0;
         strap_taken <= 1'b0;
      end
      else
      begin
         strap_taken <= 1'b1;
         if (!strap_taken && supply_control_straps_off)
            mode <= lbic_pkg::LED_MODE_HW1;
         else if (wr_b)
            mode <= pwdata[lbic_pkg::POS_LED_MODE +: 2];
         if (wr_b)
         begin
            pin47_sel <= pwdata[lbic_pkg::POS_PIN47_SEL];
            pin59_sel <= pwdata[lbic_pkg::POS_PIN59_SEL];
            pin58_sel <= pwdata[lbic_pkg::POS_PIN58_SEL];
         end
         // set wins over a clearing write
         if (intr_set)
            intr_status <= 1'b1;
         else if (wr_b && !pwdata[lbic_pkg::POS_INTR_STATUS])
            intr_status <= 1'b0;
      end
   end

   // blink register and polarity
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         led_two     <= 1'b0;
         pwr_led_s45 <= 1'b0;
         led2_rate   <= lbic_pkg::LED2_RATE_RST;
         led1_rate   <= lbic_pkg::LED1_RATE_RST;
         led_pol     <= 1'b0;
      end
      else
      begin
         if (wr_c)
         begin
            led_two     <= pwdata[lbic_pkg::POS_LED_TWO];
            pwr_led_s45 <= pwdata[lbic_pkg::POS_PWR_LED_S45];
            led1_rate   <= pwdata[lbic_pkg::POS_LED1_RATE +: 3];
         end
         if (hw1_load)
            led2_rate <= lbic_pkg::RATE_1HZ;
         else if (wr_c)
            led2_rate <= pwdata[lbic_pkg::POS_LED2_RATE +: 3];
         if (main_fall && !wr_c)
            pwr_led_s45 <= 1'b0;
         if (wr && hit_ctrl)
            led_pol <= pwdata[lbic_pkg::POS_LED_POL];
      end
   end

   // interrupt status and mask
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
      end
      else
      begin
         irq_stat[lbic_pkg::POS_IRQ_INTRUSION] <= intr_new |
            (irq_stat[lbic_pkg::POS_IRQ_INTRUSION] &
             ~(wr & hit_stat & pwdata[lbic_pkg::POS_IRQ_INTRUSION]));
         irq_stat[lbic_pkg::POS_IRQ_HWM1_LOAD] <= hw1_load |
            (irq_stat[lbic_pkg::POS_IRQ_HWM1_LOAD] &
             ~(wr & hit_stat & pwdata[lbic_pkg::POS_IRQ_HWM1_LOAD]));
         if (wr && hit_mask)
            irq_mask <= pwdata[1:0];
      end
   end

   // apb answer and outputs
   assign bl.led1_rate = led1_rate;
   assign bl.led2_rate = led2_rate;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready                         <= 1'b0;
         prdata                         <= 32'h0;
         pslverr                        <= 1'b0;
         pins_as_thermistors            <= 1'b0;
         pin59_infrared_rx_one          <= 1'b0;
         pin58_infrared_rx_two_sel_zero <= 1'b0;
         led1_out                       <= 1'b0;
         led2_out                       <= 1'b0;
         led_two_separate               <= 1'b0;
         power_led_force_off            <= 1'b0;
         led_mode                       <= lbic_pkg::LED_MODE_SW;
         irq                            <= 1'b0;
      end
      else
      begin
         // one wait state: ready in the second access cycle
         pready                         <= psel & penable & ~pready;
         prdata                         <= (psel && !pwrite) ? rd_data : 32'h0;
         pslverr                        <= psel & penable & ~pready & ~hit_any;
         pins_as_thermistors            <= pin47_sel;
         pin59_infrared_rx_one          <= pin59_sel;
         pin58_infrared_rx_two_sel_zero <= pin58_sel;
         led1_out                       <= bl.led1_wave ^ led_pol;
         led2_out                       <= (bl.led2_wave & ~pwr_off_hw2) ^ led_pol;
         led_two_separate               <= led_two;
         power_led_force_off            <= pwr_off_hw2;
         led_mode                       <= eff_mode;
         irq                            <= |(irq_stat & irq_mask);
      end
   end

   lbic_blink_gen #(.TICK_CYCLES(TICK_CYCLES)) u_gen
   (
      .pclk    (pclk),
      .presetn (presetn),
      .bl      (bl.gen)
   );
endmodule // lbic_top

// >>> test/lbic_monitor.sv
// port-level checker for the configuration block
`timescale 1ns/100ps
module lbic_monitor
(
   // apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // status
   input wire logic        supply_control_straps_off,
   input wire logic        pins_as_thermistors,
   input wire logic        power_led_force_off,
   input wire logic [1:0]  led_mode
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire wr_acc = psel && penable && pwrite;
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
   a_access_answer: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered");
   a_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
   a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("error read not zero");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_mode_legal: assert property (led_mode != 2'h3) else $error("reserved mode shown");
   a_force_off_mode: assert property (power_led_force_off |-> led_mode == 2'h2)
      else $error("force off outside mode 2");
   a_pin_cause: assert property ($changed(pins_as_thermistors) |->
      $past(wr_acc) || $past(wr_acc, 2)) else $error("pin select moved alone");
   a_strap_mode: assert property ($rose(presetn) && supply_control_straps_off |->
      ##[0:2] led_mode == 2'h1) else $error("strap mode missing");
   c_write: cover property (wr_acc && pready);
   c_slverr: cover property (pslverr);
   c_force_off: cover property (power_led_force_off);
endmodule // lbic_monitor

bind lbic_top lbic_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
   .pslverr, .supply_control_straps_off, .pins_as_thermistors, .power_led_force_off, .led_mode);

// >>> test/lbic_panel_model.sv
// front panel model: intrusion switch and led on-time meter
`timescale 1ns/100ps
module lbic_panel_model
(
   // clock
   input wire logic pclk,
   // leds and switch
   input wire logic led1_out,
   input wire logic led2_out,
   output logic     chassis_switch_in
);
   initial chassis_switch_in = 1'h0;
   task automatic set_switch(input logic v);
      @(posedge pclk);
      chassis_switch_in <= v;
   endtask
   // lit cycles over n cycles, alignment free when n is a whole period
   task automatic meter(input int n, output int h1, output int h2);
      h1 = 0;
      h2 = 0;
      repeat (n)
      begin
         @(posedge pclk);
         h1 += (led1_out === 1'h1);
         h2 += (led2_out === 1'h1);
      end
   endtask
endmodule // lbic_panel_model

// >>> test/test_lbic_top.sv
// self-checking bench for the configuration block
`timescale 1ns/100ps
module test_lbic_top;
   localparam int TK = 4;
   localparam int PER = lbic_pkg::PHASE_STEPS * TK;
   localparam logic [11:0] A_PIN = lbic_pkg::ADDR_PIN_INTRUSION_LED_MODE_CFG;
   localparam logic [11:0] A_BLK = lbic_pkg::ADDR_LED_BLINK_CFG;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
   logic        main_ok, sb_ok, straps_off, sw, therm, ir1, ir2, l1, l2, two, pwr_off;
   logic [1:0]  mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int          err_total, n_tests, h1, h2;
   int          on[8] = '{0, PER / 8, PER / 4, PER / 2, PER / 2, PER / 2, PER / 2, PER};
   lbic_top #(.TICK_CYCLES(TK)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .main_pwr_ok(main_ok), .standby_pwr_ok(sb_ok),
      .supply_control_straps_off(straps_off), .chassis_switch_in(sw),
      .pins_as_thermistors(therm), .pin59_infrared_rx_one(ir1),
      .pin58_infrared_rx_two_sel_zero(ir2), .led1_out(l1), .led2_out(l2),
      .led_two_separate(two), .power_led_force_off(pwr_off), .led_mode(mode), .irq);
   lbic_panel_model panel (.pclk, .led1_out(l1), .led2_out(l2), .chassis_switch_in(sw));
   always #2 pclk = ~pclk;
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
      n_tests++;
      if (got !== x)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, x, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'h1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) chk("pready", 32'h1, 32'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] x,
                     input string nm);
      xfer(1'h0, a, 32'h0);
      chk(nm, {24'h0, x}, {q[31:8], q[7:0] & m});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task automatic results();
      if (err_total == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (30000) @(posedge pclk);
      err_total++;
      results();
   end
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {main_ok, sb_ok, straps_off, err_total, n_tests} = {3'h6, 64'h0};
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      rd(A_PIN, 8'hFF, 8'h10, "pin cfg reset");
      rd(A_BLK, 8'hFF, 8'h38, "blink reset");
      xfer(1'h0, 12'h000, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      xfer(1'h1, A_PIN, 32'hCB);
      rd(A_PIN, 8'hFF, 8'h4B, "pin cfg write");
      chk("selects", 32'h7, {29'h0, therm, ir1, ir2});
      chk("mode two", 32'h2, {30'h0, mode});
      panel.set_switch(1'h1);
      rd(A_PIN, 8'h30, 8'h30, "intrusion high");
      panel.set_switch(1'h0);
      rd(A_PIN, 8'h30, 8'h10, "intrusion held");
      xfer(1'h1, lbic_pkg::ADDR_IRQ_MASK, 32'h0);
      wt(2);
      chk("irq masked", 32'h0, {31'h0, irq});
      xfer(1'h1, lbic_pkg::ADDR_IRQ_MASK, 32'h1);
      wt(2);
      chk("irq raised", 32'h1, {31'h0, irq});
      xfer(1'h1, lbic_pkg::ADDR_IRQ_STAT, 32'h1);
      wt(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
      xfer(1'h1, A_PIN, 32'h0C);
      rd(A_PIN, 8'h10, 8'h00, "status cleared");
      chk("reserved mode", 32'h0, {30'h0, mode});
      for (int r = 0; r < 8; r++)
      begin
         xfer(1'h1, A_BLK, {24'h0, 2'h2, 3'(7 - r), 3'(r)});
         wt(4);
         panel.meter(PER, h1, h2);
         chk("led1 lit", on[r], h1);
         chk("led2 lit", on[7 - r], h2);
      end
      rd(A_BLK, 8'hFF, 8'h87, "blink readback");
      chk("two leds", 32'h1, {31'h0, two});
      xfer(1'h1, lbic_pkg::ADDR_CTRL, 32'h1);
      wt(4);
      panel.meter(PER, h1, h2);
      chk("led1 inverted", 32'h0, h1);
      chk("led2 inverted", PER, h2);
      xfer(1'h1, A_PIN, 32'h08);
      xfer(1'h1, A_BLK, 32'h00);
      main_ok <= 1'h0;
      wt(3);
      chk("power led off", 32'h1, {31'h0, pwr_off});
      @(posedge pclk);
      main_ok <= 1'h1;
      xfer(1'h1, A_PIN, 32'h04);
      xfer(1'h1, A_BLK, 32'h38);
      main_ok <= 1'h0;
      wt(3);
      rd(A_BLK, 8'h38, 8'h18, "main loss load");
      rd(lbic_pkg::ADDR_IRQ_STAT, 8'h02, 8'h02, "load event");
      xfer(1'h1, A_BLK, 32'h38);
      sb_ok <= 1'h0;
      wt(2);
      @(posedge pclk);
      sb_ok <= 1'h1;
      wt(3);
      rd(A_BLK, 8'h38, 8'h18, "standby up load");
      @(posedge pclk);
      presetn <= 1'h0;
      straps_off <= 1'h1;
      wt(3);
      @(posedge pclk);
      presetn <= 1'h1;
      wt(3);
      chk("strap mode", 32'h1, {30'h0, mode});
      rd(A_PIN, 8'h1C, 8'h14, "strap readback");
      results();
   end
endmodule // test_lbic_top
